// file: core/recal_pkg.sv
// constants, types and register map of the flat-field and gain state controller
// What this block does
// - three recal modes: external, manual, automatic; automatic after reset
// - external mode starts a recal only on host command
// - manual mode starts on command and keeps the shutter closed throughout
// - automatic mode starts at start-up, on time limit or temperature drift
// - host can change the time limit and the temperature-change limit
// - four recal states tracked and reported in the status word
// - after reset: never-run state, factory correction terms in use
// - automatic mode only: pending state a set number of frames before start
// - running state entered on host command or on automatic start
// - default recal lasts 23 frames, 8 of them integrated
// - integrated frames are a power of two, 1 to 128; length follows
// - temperature readings flagged invalid while a recal is running
// - a finished recal moves to the done state by itself
// - wanted flag raised at start-up, on time limit or on temperature drift
// - automatic mode enters pending on the clock after the wanted flag is seen high
// - outside -10 C..+80 C: shutter locked, manual and automatic recals held off (external ones still run), lockout flag set
// - gain modes high, low, automatic; high after reset; fixed modes hold
// - automatic gain goes low when hot pixel share passes its threshold
// - automatic gain goes high when cold pixel share passes its threshold
// - gain criteria use only pixels inside the gain region of interest
// - automatic gain may only be chosen while measurement is enabled
// - log2 of integrated frames reported as its own status word
package recal_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;

    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_TIME_LIMIT = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_TEMP_LIMIT = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_PEND_FRAMES = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_LOG2_FRAMES = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_HL_TEMP = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_HL_POP = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_LH_TEMP = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_LH_POP = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_ROI_TOP = 4'h9;
    localparam logic [ADDR_W-1:0] ADDR_ROI_LEFT = 4'hA;
    localparam logic [ADDR_W-1:0] ADDR_ROI_BOTTOM = 4'hB;
    localparam logic [ADDR_W-1:0] ADDR_ROI_RIGHT = 4'hC;
    localparam logic [ADDR_W-1:0] ADDR_CMD = 4'hD;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'hE;

    // control word field positions
    localparam int CTRL_RMODE_LSB = 0;
    localparam int CTRL_GMODE_LSB = 2;
    localparam int CTRL_MEAS_BIT = 4;
    localparam int CMD_START_BIT = 0;

    // status word field positions
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_WANTED_BIT = 2;
    localparam int STAT_LOCK_BIT = 3;
    localparam int STAT_HIGH_BIT = 4;
    localparam int STAT_VALID_BIT = 5;
    localparam int STAT_FACTORY_BIT = 6;
    localparam int STAT_SHUT_BIT = 7;

    // mode encodings
    localparam logic [1:0] RM_EXTERNAL = 2'h0;
    localparam logic [1:0] RM_MANUAL = 2'h1;
    localparam logic [1:0] RM_AUTO = 2'h2;
    localparam logic [1:0] GM_HIGH = 2'h0;
    localparam logic [1:0] GM_LOW = 2'h1;
    localparam logic [1:0] GM_AUTO = 2'h2;

    // reset values
    localparam logic [1:0] RST_RMODE = RM_AUTO;
    localparam logic [1:0] RST_GMODE = GM_HIGH;
    localparam logic [15:0] RST_TIME_LIMIT_S = 16'h00B4;
    localparam logic [15:0] RST_TEMP_LIMIT_CK = 16'h0096;
    localparam logic [15:0] RST_PEND_FRAMES = 16'h0034;
    localparam logic [2:0] RST_LOG2_FRAMES = 3'h3;
    localparam logic [15:0] RST_HL_TEMP_CK = 16'h91C3;
    localparam logic [15:0] RST_HL_POP_PCT = 16'h0014;
    localparam logic [15:0] RST_LH_TEMP_CK = 16'h8E8B;
    localparam logic [15:0] RST_LH_POP_PCT = 16'h005A;
    localparam logic [15:0] RST_ROI_TOP = 16'h0000;
    localparam logic [15:0] RST_ROI_LEFT = 16'h0000;
    localparam logic [15:0] RST_ROI_BOTTOM = 16'h003B;
    localparam logic [15:0] RST_ROI_RIGHT = 16'h004F;

    // timing: recal overhead frames and the one-second tick
    localparam logic [8:0] RECAL_OVERHEAD_FRAMES = 9'h00F;
    localparam longint CLOCK_HZ = 100000000;
    localparam longint TICK_S = 1;
    localparam longint CYCLES_PER_S = CLOCK_HZ * TICK_S;

    // shutter lockout window in kelvin x 100
    localparam logic [15:0] LOCK_LOW_CK = 16'h66CB;
    localparam logic [15:0] LOCK_HIGH_CK = 16'h89F3;
    localparam logic [15:0] PCT_FULL = 16'h0064;

    typedef enum logic [1:0] {
        ST_NEVER_RUN,
        ST_PENDING,
        ST_RUNNING,
        ST_DONE
    } recal_state_t;

    // one pixel of temperature data with its position
    typedef struct packed {
        logic valid;
        logic [6:0] col;
        logic [5:0] row;
        logic [15:0] temp_ck;
    } pix_t;

    // outward status of the block
    typedef struct packed {
        recal_state_t state;
        logic wanted;
        logic lockout;
        logic shutter_close;
        logic integrate;
        logic meas_valid;
        logic factory_terms;
        logic high_gain;
        logic [15:0] log2_frames;
    } recal_status_t;

endpackage

// file: core/flat_field_and_gain_state_control.sv
// flat-field recal sequencer and gain state selector
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module flat_field_and_gain_state_control #(
    parameter longint CYCLES_PER_SEC = recal_pkg::CYCLES_PER_S
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic [recal_pkg::ADDR_W-1:0] addr_i,
    input wire logic [recal_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [recal_pkg::DATA_W-1:0] rdata_o,
    input wire logic frame_start_i,
    input wire logic [15:0] sensor_temp_ck_i,
    input wire recal_pkg::pix_t pix_i,
    output recal_pkg::recal_status_t status_o
);
    import recal_pkg::*;

    typedef struct packed {
        logic [1:0] rmode;
        logic [1:0] gmode;
        logic meas_en;
        logic [15:0] time_limit;
        logic [15:0] temp_limit;
        logic [15:0] pend_frames;
        logic [2:0] log2_frames;
        logic [15:0] hl_temp;
        logic [15:0] hl_pop;
        logic [15:0] lh_temp;
        logic [15:0] lh_pop;
        logic [15:0] roi_top;
        logic [15:0] roi_left;
        logic [15:0] roi_bottom;
        logic [15:0] roi_right;
        recal_state_t state;
        logic startup;
        logic shut_hold;
        logic [15:0] pend_cnt;
        logic [8:0] run_cnt;
        logic [31:0] tick_cnt;
        logic [15:0] elapsed_s;
        logic [15:0] ref_temp;
        logic factory;
        logic high_gain;
        logic lockout;
        logic [12:0] roi_total;
        logic [12:0] roi_hot;
        logic [12:0] roi_cold;
        logic [15:0] rdata;
    } state_t;

    state_t cur;
    state_t next_cur;

    // pixel lies inside the gain region, bounds inclusive
    function automatic logic in_roi(input pix_t p, input state_t s);
        in_roi = ({9'h000, p.col} >= s.roi_left) && ({9'h000, p.col} <= s.roi_right) &&
                 ({10'h000, p.row} >= s.roi_top) && ({10'h000, p.row} <= s.roi_bottom);
    endfunction

    // share test: count/total > pct/100, done by cross multiplication
    function automatic logic share_over(input logic [12:0] cnt, input logic [12:0] total,
                                        input logic [15:0] pct);
        logic [31:0] lhs;
        logic [31:0] rhs;
        lhs = {19'h0_0000, cnt} * {16'h0000, PCT_FULL};
        rhs = {19'h0_0000, total} * {16'h0000, pct};
        share_over = (total != 13'h0000) && (lhs > rhs);
    endfunction

    logic [16:0] temp_diff;
    logic [15:0] temp_drift;
    logic time_over;
    logic drift_over;
    logic wanted;
    logic start_cmd;
    logic cmd_accept;
    logic [8:0] run_total;
    logic tick;
    logic [1:0] wr_rmode;
    logic [1:0] wr_gmode;
    logic wr_meas;

    // drift magnitude against the temperature captured at the last recal
    always_comb begin
        temp_diff = {1'b0, sensor_temp_ck_i} - {1'b0, cur.ref_temp};
        if (temp_diff[16]) begin
            temp_drift = 16'(~temp_diff + 17'h0_0001);
        end else begin
            temp_drift = temp_diff[15:0];
        end
    end

    assign time_over = cur.elapsed_s > cur.time_limit;
    assign drift_over = temp_drift > cur.temp_limit;
    // the wanted flag is level driven, so a new cause is never lost to a clear
    assign wanted = cur.startup || time_over || drift_over;
    assign tick = cur.tick_cnt == 32'(CYCLES_PER_SEC - 1);
    assign start_cmd = wr_i && (addr_i == ADDR_CMD) && wdata_i[CMD_START_BIT];
    // external mode never uses the shutter, so lockout does not refuse it
    assign cmd_accept = start_cmd && (cur.state != ST_RUNNING) &&
                        ((cur.rmode == RM_EXTERNAL) || !cur.lockout);
    assign run_total = RECAL_OVERHEAD_FRAMES + (9'h001 << cur.log2_frames);
    assign wr_rmode = wdata_i[CTRL_RMODE_LSB +: 2];
    assign wr_gmode = wdata_i[CTRL_GMODE_LSB +: 2];
    assign wr_meas = wdata_i[CTRL_MEAS_BIT];

    // all next-state logic of the block
    always_comb begin
        next_cur = cur;
        next_cur.rdata = 16'h0000;

        // shutter lockout is sampled every cycle from the sensor reading
        next_cur.lockout = (sensor_temp_ck_i < LOCK_LOW_CK) ||
                           (sensor_temp_ck_i > LOCK_HIGH_CK);

        // one-second tick drives the elapsed-time count, saturating
        if (tick) begin
            next_cur.tick_cnt = 32'h0000_0000;
            if (cur.elapsed_s != 16'hFFFF) begin
                next_cur.elapsed_s = cur.elapsed_s + 16'h0001;
            end
        end else begin
            next_cur.tick_cnt = cur.tick_cnt + 32'h0000_0001;
        end

        // register writes; invalid mode codes leave the old mode in place
        if (wr_i) begin
            case (addr_i)
                ADDR_CTRL: begin
                    next_cur.meas_en = wr_meas;
                    if (wr_rmode != 2'h3) begin
                        next_cur.rmode = wr_rmode;
                    end
                    if ((wr_gmode == GM_HIGH) || (wr_gmode == GM_LOW) ||
                        ((wr_gmode == GM_AUTO) && wr_meas)) begin
                        next_cur.gmode = wr_gmode;
                    end
                end
                ADDR_TIME_LIMIT: next_cur.time_limit = wdata_i;
                ADDR_TEMP_LIMIT: next_cur.temp_limit = wdata_i;
                ADDR_PEND_FRAMES: next_cur.pend_frames = wdata_i;
                ADDR_LOG2_FRAMES: begin
                    // length is only changed between recals so a run keeps its count
                    if (cur.state != ST_RUNNING) begin
                        next_cur.log2_frames = wdata_i[2:0];
                    end
                end
                ADDR_HL_TEMP: next_cur.hl_temp = wdata_i;
                ADDR_HL_POP: next_cur.hl_pop = wdata_i;
                ADDR_LH_TEMP: next_cur.lh_temp = wdata_i;
                ADDR_LH_POP: next_cur.lh_pop = wdata_i;
                ADDR_ROI_TOP: next_cur.roi_top = wdata_i;
                ADDR_ROI_LEFT: next_cur.roi_left = wdata_i;
                ADDR_ROI_BOTTOM: next_cur.roi_bottom = wdata_i;
                ADDR_ROI_RIGHT: next_cur.roi_right = wdata_i;
                default: begin
                end
            endcase
        end

        // automatic gain falls back to high if measurement is switched off
        if ((cur.gmode == GM_AUTO) && !cur.meas_en) begin
            next_cur.gmode = GM_HIGH;
        end

        // recal progress machine
        case (cur.state)
            ST_NEVER_RUN, ST_DONE: begin
                if (cmd_accept) begin
                    next_cur.state = ST_RUNNING;
                    next_cur.run_cnt = 9'h000;
                    next_cur.shut_hold = cur.rmode != RM_EXTERNAL;
                end else if ((cur.rmode == RM_AUTO) && wanted && !cur.lockout) begin
                    next_cur.state = ST_PENDING;
                    next_cur.pend_cnt = cur.pend_frames;
                end
            end
            ST_PENDING: begin
                // leaving auto mode abandons the warning without a recal
                if (cmd_accept) begin
                    next_cur.state = ST_RUNNING;
                    next_cur.run_cnt = 9'h000;
                    next_cur.shut_hold = cur.rmode != RM_EXTERNAL;
                end else if (cur.rmode != RM_AUTO) begin
                    next_cur.state = cur.factory ? ST_NEVER_RUN : ST_DONE;
                end else if (cur.pend_cnt == 16'h0000) begin
                    if (!cur.lockout) begin
                        next_cur.state = ST_RUNNING;
                        next_cur.run_cnt = 9'h000;
                        next_cur.shut_hold = 1'b1;
                    end
                end else if (frame_start_i) begin
                    next_cur.pend_cnt = cur.pend_frames == 16'h0000 ? 16'h0000 :
                                        cur.pend_cnt - 16'h0001;
                end
            end
            ST_RUNNING: begin
                if (frame_start_i) begin
                    if (cur.run_cnt == run_total - 9'h001) begin
                        next_cur.state = ST_DONE;
                        next_cur.factory = 1'b0;
                        next_cur.startup = 1'b0;
                        next_cur.elapsed_s = 16'h0000;
                        next_cur.tick_cnt = 32'h0000_0000;
                        next_cur.ref_temp = sensor_temp_ck_i;
                        next_cur.shut_hold = 1'b0;
                    end else begin
                        next_cur.run_cnt = cur.run_cnt + 9'h001;
                    end
                end
            end
            default: begin
                next_cur.state = ST_NEVER_RUN;
            end
        endcase

        // region statistics close at each frame start and feed the gain choice
        if (frame_start_i) begin
            case (cur.gmode)
                GM_HIGH: next_cur.high_gain = 1'b1;
                GM_LOW: next_cur.high_gain = 1'b0;
                GM_AUTO: begin
                    if (cur.high_gain && share_over(cur.roi_hot, cur.roi_total,
                                                    cur.hl_pop)) begin
                        next_cur.high_gain = 1'b0;
                    end else if (!cur.high_gain && share_over(cur.roi_cold,
                                                              cur.roi_total, cur.lh_pop)) begin
                        next_cur.high_gain = 1'b1;
                    end
                end
                default: next_cur.high_gain = 1'b1;
            endcase
            next_cur.roi_total = 13'h0000;
            next_cur.roi_hot = 13'h0000;
            next_cur.roi_cold = 13'h0000;
        end else if (pix_i.valid && in_roi(pix_i, cur)) begin
            // counters saturate; a full sensor frame never reaches the top
            if (cur.roi_total != 13'h1FFF) begin
                next_cur.roi_total = cur.roi_total + 13'h0001;
            end
            if ((pix_i.temp_ck > cur.hl_temp) && (cur.roi_hot != 13'h1FFF)) begin
                next_cur.roi_hot = cur.roi_hot + 13'h0001;
            end
            if ((pix_i.temp_ck < cur.lh_temp) && (cur.roi_cold != 13'h1FFF)) begin
                next_cur.roi_cold = cur.roi_cold + 13'h0001;
            end
        end

        // read data stands one cycle after the strobe; unmapped reads give zero
        if (rd_i) begin
            case (addr_i)
                ADDR_CTRL: begin
                    next_cur.rdata[CTRL_RMODE_LSB +: 2] = cur.rmode;
                    next_cur.rdata[CTRL_GMODE_LSB +: 2] = cur.gmode;
                    next_cur.rdata[CTRL_MEAS_BIT] = cur.meas_en;
                end
                ADDR_TIME_LIMIT: next_cur.rdata = cur.time_limit;
                ADDR_TEMP_LIMIT: next_cur.rdata = cur.temp_limit;
                ADDR_PEND_FRAMES: next_cur.rdata = cur.pend_frames;
                ADDR_LOG2_FRAMES: next_cur.rdata = {13'h0000, cur.log2_frames};
                ADDR_HL_TEMP: next_cur.rdata = cur.hl_temp;
                ADDR_HL_POP: next_cur.rdata = cur.hl_pop;
                ADDR_LH_TEMP: next_cur.rdata = cur.lh_temp;
                ADDR_LH_POP: next_cur.rdata = cur.lh_pop;
                ADDR_ROI_TOP: next_cur.rdata = cur.roi_top;
                ADDR_ROI_LEFT: next_cur.rdata = cur.roi_left;
                ADDR_ROI_BOTTOM: next_cur.rdata = cur.roi_bottom;
                ADDR_ROI_RIGHT: next_cur.rdata = cur.roi_right;
                ADDR_STATUS: begin
                    next_cur.rdata[STAT_STATE_LSB +: 2] = cur.state;
                    next_cur.rdata[STAT_WANTED_BIT] = wanted;
                    next_cur.rdata[STAT_LOCK_BIT] = cur.lockout;
                    next_cur.rdata[STAT_HIGH_BIT] = cur.high_gain;
                    next_cur.rdata[STAT_VALID_BIT] = cur.state != ST_RUNNING;
                    next_cur.rdata[STAT_FACTORY_BIT] = cur.factory;
                    next_cur.rdata[STAT_SHUT_BIT] = cur.shut_hold &&
                                                    (cur.state == ST_RUNNING);
                end
                default: next_cur.rdata = 16'h0000;
            endcase
        end

        // synchronous reset overrides everything
        if (srst_i) begin
            next_cur = '0;
            next_cur.rmode = RST_RMODE;
            next_cur.gmode = RST_GMODE;
            next_cur.time_limit = RST_TIME_LIMIT_S;
            next_cur.temp_limit = RST_TEMP_LIMIT_CK;
            next_cur.pend_frames = RST_PEND_FRAMES;
            next_cur.log2_frames = RST_LOG2_FRAMES;
            next_cur.hl_temp = RST_HL_TEMP_CK;
            next_cur.hl_pop = RST_HL_POP_PCT;
            next_cur.lh_temp = RST_LH_TEMP_CK;
            next_cur.lh_pop = RST_LH_POP_PCT;
            next_cur.roi_top = RST_ROI_TOP;
            next_cur.roi_left = RST_ROI_LEFT;
            next_cur.roi_bottom = RST_ROI_BOTTOM;
            next_cur.roi_right = RST_ROI_RIGHT;
            next_cur.state = ST_NEVER_RUN;
            next_cur.startup = 1'b1;
            next_cur.factory = 1'b1;
            next_cur.high_gain = 1'b1;
        end
    end

    // single state register
    always_ff @(posedge ref_clk_i) begin
        cur <= next_cur;
    end

    // outputs straight from state, except wanted, which also follows the live sensor reading; meas_valid drops while running
    assign rdata_o = cur.rdata;
    assign status_o.state = cur.state;
    assign status_o.wanted = wanted;
    assign status_o.lockout = cur.lockout;
    assign status_o.shutter_close = cur.shut_hold && (cur.state == ST_RUNNING);
    assign status_o.integrate = (cur.state == ST_RUNNING) &&
                                (cur.run_cnt >= RECAL_OVERHEAD_FRAMES);
    assign status_o.meas_valid = cur.state != ST_RUNNING;
    assign status_o.factory_terms = cur.factory;
    assign status_o.high_gain = cur.high_gain;
    assign status_o.log2_frames = {13'h0000, cur.log2_frames};

endmodule

// file: test/recal_asserts.sv
// concurrent checks on the recal and gain controller ports
`timescale 1ns/100ps
module recal_asserts #(
    parameter longint CYCLES_PER_SEC = 10
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic [recal_pkg::ADDR_W-1:0] addr_i,
    input wire logic [recal_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [recal_pkg::DATA_W-1:0] rdata_o,
    input wire logic frame_start_i,
    input wire logic [15:0] sensor_temp_ck_i,
    input wire recal_pkg::pix_t pix_i,
    input wire recal_pkg::recal_status_t status_o
);
    import recal_pkg::*;
    logic [7:0] word;
    // status word as the read port must pack it
    assign word = {status_o.shutter_close, status_o.factory_terms, status_o.meas_valid,
        status_o.high_gain, status_o.lockout, status_o.wanted, status_o.state};
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    property p_meas; status_o.state == ST_RUNNING |-> !status_o.meas_valid; endproperty
    a_meas: assert property (p_meas) else $error("reading valid while running");
    property p_rd; rd_i && addr_i == ADDR_STATUS |=> rdata_o[7:0] == $past(word); endproperty
    a_rd: assert property (p_rd) else $error("status read differs");
    property p_lg; wr_i && addr_i == ADDR_LOG2_FRAMES && status_o.state != ST_RUNNING
        |=> status_o.log2_frames[2:0] == $past(wdata_i[2:0]); endproperty
    a_lg: assert property (p_lg) else $error("frame log not reported");
    property p_end; status_o.state == ST_RUNNING ##1 status_o.state != ST_RUNNING
        |-> status_o.state == ST_DONE; endproperty
    a_end: assert property (p_end) else $error("run did not end in done");
    property p_hold; status_o.state == ST_RUNNING && !frame_start_i
        |=> status_o.state == ST_RUNNING; endproperty
    a_hold: assert property (p_hold) else $error("run ended off a frame");
    property p_fact; status_o.state == ST_DONE |-> !status_o.factory_terms; endproperty
    a_fact: assert property (p_fact) else $error("factory terms after run");
    property p_pend; $rose(status_o.state == ST_PENDING) |-> $past(status_o.wanted); endproperty
    a_pend: assert property (p_pend) else $error("pending without wanted");
    property p_cmd; wr_i && addr_i == ADDR_CMD && wdata_i[0] && status_o.state != ST_RUNNING
        && !status_o.lockout |=> status_o.state == ST_RUNNING; endproperty
    a_cmd: assert property (p_cmd) else $error("start command lost");
    property p_lock; 1 |=> status_o.lockout == ($past(sensor_temp_ck_i) < LOCK_LOW_CK
        || $past(sensor_temp_ck_i) > LOCK_HIGH_CK); endproperty
    a_lock: assert property (p_lock) else $error("lockout flag wrong");
    c_pend: cover property (status_o.state == ST_PENDING);
    c_run: cover property (status_o.state == ST_RUNNING);
    c_lock: cover property (status_o.lockout);
endmodule
bind flat_field_and_gain_state_control recal_asserts #(.CYCLES_PER_SEC(CYCLES_PER_SEC))
    recal_asserts_inst (.ref_clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .frame_start_i, .sensor_temp_ck_i, .pix_i, .status_o);

// file: test/scene_src.sv
// frame pulse and pixel source standing in for the sensor front end
`timescale 1ns/100ps
module scene_src #(
    parameter int PER = 20
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic [15:0] scene_temp_i,
    output logic frame_start_o,
    output recal_pkg::pix_t pix_o
);
    import recal_pkg::*;
    logic [6:0] cnt;
    // one pulse per frame; pixels of row 0 fill the rest, all at scene temperature
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            cnt <= 7'h00;
            frame_start_o <= 1'b0;
            pix_o <= '0;
        end else begin
            cnt <= (cnt == 7'(PER - 1)) ? 7'h00 : cnt + 7'h01;
            frame_start_o <= (cnt == 7'(PER - 1));
            pix_o <= '{valid: cnt != 7'h00, col: cnt, row: 6'h00, temp_ck: scene_temp_i};
        end
    end
endmodule

// file: test/tb_top.sv
// self-checking bench for the recal sequencer and gain selector
`timescale 1ns/100ps
module tb_top;
    import recal_pkg::*;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic [15:0] sens_temp = 16'h7530;
    logic [15:0] scene_temp = 16'h7530;
    logic fs;
    pix_t pix;
    recal_status_t st;
    int err_total = 0;
    int n_compared = 0;
    int n;
    int m;
    logic [15:0] rst_tbl [16] = '{16'h0000, 16'h00B4, 16'h0096, 16'h0034, 16'h0003, 16'h91C3,
        16'h0014, 16'h8E8B, 16'h005A, 16'h0000, 16'h0000, 16'h003B, 16'h004F, 16'h0000,
        16'h0033, 16'h0000};
    always #5 ref_clk_i = ~ref_clk_i;
    flat_field_and_gain_state_control #(.CYCLES_PER_SEC(10)) flat_field_and_gain_state_control_inst (
        .ref_clk_i, .srst_i, .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .frame_start_i(fs), .sensor_temp_ck_i(sens_temp), .pix_i(pix),
        .status_o(st));
    scene_src scene_src_inst (.ref_clk_i, .srst_i, .scene_temp_i(scene_temp),
        .frame_start_o(fs), .pix_o(pix));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // a wait that ran out means a stuck design: report and stop
    task automatic bound(input int i);
        if (i >= 4000) begin
            err_total++;
            $display("MISMATCH t=%0t wait ran out", $time);
            close_out();
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
        @(posedge ref_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_i);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    // frame pulses seen while the state holds at s
    task automatic count_in(input recal_state_t s, output int cnt);
        int i;
        cnt = 0;
        @(negedge ref_clk_i);
        for (i = 0; i < 4000 && st.state !== s; i++) @(negedge ref_clk_i);
        bound(i);
        for (i = 0; i < 4000 && st.state === s; i++) begin
            cnt += int'(fs === 1'b1);
            @(negedge ref_clk_i);
        end
        bound(i);
    endtask
    // start just after a frame pulse so the entry edge never carries one
    task automatic cmd_start();
        int i;
        for (i = 0; i < 4000 && fs !== 1'b1; i++) @(negedge ref_clk_i);
        bound(i);
        wr_reg(ADDR_CMD, 16'h0001);
    endtask
    task automatic gain_is(input logic [3:0] a, input logic [15:0] d, input logic hi);
        wr_reg(a, d);
        repeat (45) @(negedge ref_clk_i);
        chk(16'(st.high_gain), 16'(hi));
    endtask
    initial begin
        void'($urandom(29));
        repeat (2) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        @(negedge ref_clk_i);
        chk(16'({st.log2_frames[2:0], st.factory_terms, st.high_gain}), 16'h000F);
        count_in(ST_PENDING, n);
        chk(16'(n), 16'h0034);
        chk(16'({st.meas_valid, st.shutter_close, st.integrate}), 16'h0002);
        count_in(ST_RUNNING, n);
        chk(16'(n), 16'h0017);
        chk(16'({st.state, st.factory_terms, st.wanted}), 16'h000C);
        for (int a = 1; a < 16; a++) begin
            rd_reg(4'(a), rst_tbl[a]);
        end
        $display("test auto run end");
        wr_reg(ADDR_CTRL, 16'h0010);
        for (int k = 0; k < 3; k++) begin
            n = (k == 0) ? 0 : (k == 1) ? 7 : int'($urandom_range(1, 6));
            wr_reg(ADDR_LOG2_FRAMES, 16'(n));
            rd_reg(ADDR_LOG2_FRAMES, 16'(n));
            chk(st.log2_frames, 16'(n));
            cmd_start();
            count_in(ST_RUNNING, m);
            chk(16'(m), 16'(15 + (1 << n)));
        end
        for (m = 0; m < 4000 && st.wanted !== 1'b1; m++) @(negedge ref_clk_i);
        bound(m);
        repeat (100) @(negedge ref_clk_i);
        chk(16'(st.state), 16'(ST_DONE));
        $display("test external end");
        wr_reg(ADDR_CTRL, 16'h0011);
        sens_temp <= 16'h8A00;
        repeat (3) @(negedge ref_clk_i);
        chk(16'(st.lockout), 16'h0001);
        cmd_start();
        sens_temp <= 16'h7530;
        repeat (3) @(negedge ref_clk_i);
        chk(16'(st.state), 16'(ST_DONE));
        chk(16'(st.lockout), 16'h0000);
        cmd_start();
        @(negedge ref_clk_i);
        chk(16'({st.state, st.shutter_close}), 16'h0005);
        count_in(ST_RUNNING, m);
        $display("test manual lockout end");
        gain_is(ADDR_CTRL, 16'h0004, 1'b0);
        gain_is(ADDR_CTRL, 16'h0008, 1'b0);
        gain_is(ADDR_CTRL, 16'h0018, 1'b1);
        scene_temp <= 16'h9600;
        gain_is(ADDR_ROI_TOP, 16'h0001, 1'b1);
        gain_is(ADDR_ROI_TOP, 16'h0000, 1'b0);
        $display("test gain end");
        close_out();
    end
endmodule
